// *** pkg/cs_regs.vh ***
// constants for the carrier-sense engine: state codes, commands, end statuses, results
// assumes the includer works in Verilog-2005 or SystemVerilog with implicit nets switched off
//
// Functional notes
// - separate BUSY/IDLE/INVALID state per source
// - strength idle/busy after consecutive samples vs threshold
// - correlation starts INVALID, IDLE without early peak
// - IDLE to INVALID after invalid-count spaced peaks
// - INVALID to BUSY; busy count zero skips INVALID
// - not IDLE and timeout since peak gives IDLE
// - single enabled source is the channel state
// - both sources combined by combine select table
// - busy change: continue, end, or stop sniff sensing
// - idle change ends with done-idle when selected
// - standalone end trigger status from channel state
// - standalone synth off per outcome and off bits
// - standalone result TRUE or FALSE per status
// - stop gives stopped/FALSE, abort gives abort/ABORT
// - parameter, setup, synth errors end with ABORT
// - sniff commands are receive plus sensing
// - sniff end trigger action per channel state
// - sensing resumes after sync search restarts
// - sensing starts once receiver ready; correlator preamble
`ifndef CS_REGS_VH
`define CS_REGS_VH

// ==========================================================
// channel state codes
`define CH_INVALID 2'h0
`define CH_IDLE    2'h1
`define CH_BUSY    2'h2

// ==========================================================
// command kinds
`define CMD_STANDALONE  2'h0
`define CMD_SNIFF_BASIC 2'h1
`define CMD_SNIFF_ADV   2'h2

// ==========================================================
// end trigger kinds
`define TRIG_NEVER 2'h0
`define TRIG_ABS   2'h1
`define TRIG_REL   2'h2

// ==========================================================
// end status codes
`define ST_NONE         4'h0
`define ST_DONE_BUSY    4'h1
`define ST_DONE_IDLE    4'h2
`define ST_BUSY_TIMEOUT 4'h3
`define ST_IDLE_TIMEOUT 4'h4
`define ST_STOPPED      4'h5
`define ST_ABORT        4'h6
`define ST_ERR_PAR      4'h7
`define ST_ERR_SETUP    4'h8
`define ST_ERR_SYNTH    4'h9

// ==========================================================
// result codes
`define RES_TRUE  2'h0
`define RES_FALSE 2'h1
`define RES_ABORT 2'h2

`endif

// *** hdl/strength_tracker.v ***
// signal-strength channel state from consecutive threshold comparisons
// assumes sampleValid pulses once per new strength sample
`timescale 1ns/1ps
`default_nettype none
`include "cs_regs.vh"

module strength_tracker (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // control
  input  wire       clear,
  input  wire       enable,
  // configuration
  input  wire [7:0] threshold,
  input  wire [7:0] idleCount,
  input  wire [7:0] busyCount,
  // samples
  input  wire       sampleValid,
  input  wire [7:0] sample,
  // state out
  output reg  [1:0] strengthState
);

  reg  [7:0] belowCnt_q;
  reg  [7:0] aboveCnt_q;
  wire       below = $signed(sample) < $signed(threshold);
  wire       above = $signed(sample) > $signed(threshold);

  // ==========================================================
  // consecutive run counters, saturating
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      belowCnt_q <= 8'h00;
      aboveCnt_q <= 8'h00;
    end else if (clear) begin
      belowCnt_q <= 8'h00;
      aboveCnt_q <= 8'h00;
    end else if (enable && sampleValid) begin
      belowCnt_q <= below ? ((belowCnt_q == 8'hFF) ? 8'hFF : belowCnt_q + 8'h01) : 8'h00;
      aboveCnt_q <= above ? ((aboveCnt_q == 8'hFF) ? 8'hFF : aboveCnt_q + 8'h01) : 8'h00;
    end
  end

  // ==========================================================
  // a sample equal to the threshold breaks both runs
  always @* begin
    if (belowCnt_q != 8'h00 && belowCnt_q >= idleCount)
      strengthState = `CH_IDLE;
    else if (aboveCnt_q != 8'h00 && aboveCnt_q >= busyCount)
      strengthState = `CH_BUSY;
    else
      strengthState = `CH_INVALID;
  end

endmodule
`default_nettype wire

// *** hdl/carrier_sense_engine.v ***
// carrier-sense engine: per-source channel states, combination, end decisions
// assumes the radio timer is free running and all inputs are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "cs_regs.vh"

module carrier_sense_engine (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // command
  input  wire        cmdStart,
  input  wire [1:0]  cmdKind,
  input  wire        stopReq,
  input  wire        abortReq,
  input  wire        radioSetupOk,
  input  wire        synthProgrammed,
  // configuration
  input  wire        strengthSourceEnable,
  input  wire        correlationSourceEnable,
  input  wire [7:0]  strengthThreshold,
  input  wire [7:0]  strengthIdleCount,
  input  wire [7:0]  strengthBusyCount,
  input  wire [31:0] correlationPeriod,
  input  wire [3:0]  correlationInvalidCount,
  input  wire [3:0]  correlationBusyCount,
  input  wire [3:0]  correlationIdleCount,
  input  wire [31:0] correlationTimeout,
  input  wire        combineSelect,
  input  wire        busyAction,
  input  wire        idleAction,
  input  wire        timeoutSelector,
  input  wire [1:0]  endTriggerKind,
  input  wire [31:0] endTriggerTime,
  input  wire        synthOffOnBusy,
  input  wire        synthOffOnIdle,
  // radio and modem
  input  wire [31:0] radioTimer,
  input  wire        receiverReady,
  input  wire        strengthValid,
  input  wire [7:0]  strengthSample,
  input  wire        corrPeak,
  input  wire        syncFound,
  input  wire        syncSearchRestart,
  // status
  output wire        cmdBusy,
  output wire        senseActive,
  output wire        correlatorPreamble,
  output wire [1:0]  strengthState,
  output wire [1:0]  correlationState,
  output reg  [1:0]  channelState,
  output reg         opDone,
  output reg  [3:0]  doneStatus,
  output reg  [1:0]  doneResult,
  output reg         synthOff
);

  // ==========================================================
  // control states
  localparam S_OFF   = 3'd0;
  localparam S_WAIT  = 3'd1;
  localparam S_SENSE = 3'd2;
  localparam S_HOLD  = 3'd3;
  localparam S_RXONLY = 3'd4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  kind_q;
  reg  [31:0] startTime_q;
  reg  [1:0]  corrState_q;
  reg  [1:0]  corrState_d;
  reg  [31:0] lastPeak_q;
  reg         havePeak_q;
  reg  [3:0]  peakRun_q;
  reg  [3:0]  peakRun_d;
  reg  [1:0]  prevChan_q;
  reg         trigFired_q;

  wire sensing    = (state_q == S_SENSE);
  wire running    = (state_q != S_OFF);
  wire standalone = (kind_q == `CMD_STANDALONE);
  wire startNow   = cmdStart && !running;

  assign cmdBusy            = running;
  assign senseActive        = sensing;
  assign correlatorPreamble = running && correlationSourceEnable;
  assign correlationState   = corrState_q;

  // ==========================================================
  // signal-strength source
  strength_tracker strengthTrack (
    .clock         (clock),
    .rst           (rst),
    .clear         (startNow),
    .enable        (sensing && strengthSourceEnable),
    .threshold     (strengthThreshold),
    .idleCount     (strengthIdleCount),
    .busyCount     (strengthBusyCount),
    .sampleValid   (strengthValid),
    .sample        (strengthSample),
    .strengthState (strengthState)
  );

  // ==========================================================
  // correlation source, all spacing on the shared radio timer
  wire [31:0] sinceStart = radioTimer - startTime_q;
  wire [31:0] sincePeak  = radioTimer - lastPeak_q;
  wire        closePeak  = havePeak_q && (sincePeak <= correlationPeriod);

  always @* begin
    corrState_d = corrState_q;
    peakRun_d   = peakRun_q;
    if (corrPeak) begin
      peakRun_d = closePeak ? ((peakRun_q == 4'hF) ? 4'hF : peakRun_q + 4'h1) : 4'h1;
      case (corrState_q)
        `CH_IDLE: begin
          if (correlationBusyCount == 4'h0 && peakRun_d >= correlationInvalidCount) begin
            corrState_d = `CH_BUSY;
            peakRun_d   = 4'h0;
          end else if (peakRun_d >= correlationInvalidCount) begin
            corrState_d = `CH_INVALID;
            peakRun_d   = 4'h0;
          end
        end
        `CH_INVALID: begin
          if (peakRun_d >= correlationBusyCount) begin
            corrState_d = `CH_BUSY;
            peakRun_d   = 4'h0;
          end
        end
        default: ;
      endcase
    end else if (corrState_q != `CH_IDLE && havePeak_q && sincePeak >= correlationTimeout) begin
      corrState_d = `CH_IDLE;
      peakRun_d   = 4'h0;
    end else if (!havePeak_q && corrState_q == `CH_INVALID && sinceStart >= correlationPeriod) begin
      corrState_d = `CH_IDLE;
      peakRun_d   = 4'h0;
    end
  end

  // ==========================================================
  // channel state from enabled sources
  always @* begin
    if (strengthSourceEnable && !correlationSourceEnable)
      channelState = strengthState;
    else if (!strengthSourceEnable)
      channelState = corrState_q;
    else if (!combineSelect) begin
      if (strengthState == `CH_BUSY || corrState_q == `CH_BUSY)
        channelState = `CH_BUSY;
      else if (strengthState == `CH_IDLE && corrState_q == `CH_IDLE)
        channelState = `CH_IDLE;
      else
        channelState = `CH_INVALID;
    end else begin
      if (strengthState == `CH_IDLE || corrState_q == `CH_IDLE)
        channelState = `CH_IDLE;
      else if (strengthState == `CH_BUSY && corrState_q == `CH_BUSY)
        channelState = `CH_BUSY;
      else
        channelState = `CH_INVALID;
    end
  end

  // ==========================================================
  // end trigger, observed once per command
  reg trigHit;
  always @* begin
    trigHit = 1'b0;
    // absolute time is reached when it lies less than half the timer range behind
    if (endTriggerKind == `TRIG_ABS)
      trigHit = !(radioTimer - endTriggerTime >= 32'h80000000);
    else if (endTriggerKind == `TRIG_REL)
      trigHit = sinceStart >= endTriggerTime;
  end
  wire trigger = sensing && trigHit && !trigFired_q;

  // ==========================================================
  // end decisions; abort over stop over trigger over state change
  wire badParam = !(strengthSourceEnable || correlationSourceEnable) ||
                  (correlationSourceEnable && correlationIdleCount == 4'h0);
  wire toBusy   = (channelState == `CH_BUSY) && (prevChan_q != `CH_BUSY);
  wire toIdle   = (channelState == `CH_IDLE) && (prevChan_q != `CH_IDLE);

  reg       fin;
  reg [3:0] finStatus;
  reg       dropSense;

  always @* begin
    fin       = 1'b0;
    finStatus = `ST_NONE;
    dropSense = 1'b0;
    if (startNow) begin
      fin = 1'b1;
      if (badParam)
        finStatus = `ST_ERR_PAR;
      else if (cmdKind == `CMD_STANDALONE && !radioSetupOk)
        finStatus = `ST_ERR_SETUP;
      else if (cmdKind == `CMD_STANDALONE && !synthProgrammed)
        finStatus = `ST_ERR_SYNTH;
      else
        fin = 1'b0;
    end else if (running && abortReq) begin
      fin       = 1'b1;
      finStatus = `ST_ABORT;
    end else if (running && stopReq) begin
      fin       = 1'b1;
      finStatus = `ST_STOPPED;
    end else if (trigger) begin
      if (standalone) begin
        fin = 1'b1;
        case (channelState)
          `CH_BUSY: finStatus = `ST_DONE_BUSY;
          `CH_IDLE: finStatus = `ST_DONE_IDLE;
          default:  finStatus = timeoutSelector ? `ST_IDLE_TIMEOUT : `ST_BUSY_TIMEOUT;
        endcase
      end else if (channelState == `CH_IDLE) begin
        fin       = 1'b1;
        finStatus = `ST_DONE_IDLE;
      end else if (channelState == `CH_INVALID) begin
        fin       = timeoutSelector;
        finStatus = timeoutSelector ? `ST_IDLE_TIMEOUT : `ST_NONE;
        dropSense = !timeoutSelector && busyAction;
      end
    end else if (sensing && toBusy && busyAction) begin
      if (standalone) begin
        fin       = 1'b1;
        finStatus = `ST_DONE_BUSY;
      end else
        dropSense = 1'b1;
    end else if (sensing && toIdle && idleAction) begin
      fin       = 1'b1;
      finStatus = `ST_DONE_IDLE;
    end
  end

  // ==========================================================
  // command sequencing
  always @* begin
    state_d = state_q;
    if (fin)
      state_d = S_OFF;
    else if (startNow)
      state_d = S_WAIT;
    else if (dropSense)
      state_d = S_RXONLY;
    else begin
      case (state_q)
        S_WAIT:  if (receiverReady) state_d = S_SENSE;
        S_SENSE: if (!standalone && syncFound) state_d = S_HOLD;
        S_HOLD:  if (syncSearchRestart) state_d = S_SENSE;
        default: ;
      endcase
    end
  end

  // result and synthesizer decisions for the ending status
  reg [1:0] finResult;
  reg       finSynthOff;
  always @* begin
    case (finStatus)
      `ST_DONE_BUSY, `ST_BUSY_TIMEOUT: begin
        finResult   = `RES_TRUE;
        finSynthOff = synthOffOnBusy;
      end
      `ST_DONE_IDLE, `ST_IDLE_TIMEOUT: begin
        finResult   = `RES_FALSE;
        finSynthOff = synthOffOnIdle;
      end
      `ST_STOPPED: begin
        finResult   = `RES_FALSE;
        finSynthOff = synthOffOnBusy || synthOffOnIdle;
      end
      default: begin
        finResult   = `RES_ABORT;
        finSynthOff = synthOffOnBusy || synthOffOnIdle;
      end
    endcase
  end

  wire finStandalone = startNow ? (cmdKind == `CMD_STANDALONE) : standalone;

  // ==========================================================
  // registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q     <= S_OFF;
      kind_q      <= `CMD_STANDALONE;
      startTime_q <= 32'h00000000;
      corrState_q <= `CH_INVALID;
      lastPeak_q  <= 32'h00000000;
      havePeak_q  <= 1'b0;
      peakRun_q   <= 4'h0;
      prevChan_q  <= `CH_INVALID;
      trigFired_q <= 1'b0;
      opDone      <= 1'b0;
      doneStatus  <= `ST_NONE;
      doneResult  <= `RES_FALSE;
      synthOff    <= 1'b0;
    end else begin
      state_q  <= state_d;
      opDone   <= fin;
      synthOff <= fin && finStandalone && finSynthOff;
      if (fin) begin
        doneStatus <= finStatus;
        doneResult <= finResult;
      end
      if (startNow) begin
        kind_q      <= cmdKind;
        startTime_q <= radioTimer;
        corrState_q <= `CH_INVALID;
        havePeak_q  <= 1'b0;
        peakRun_q   <= 4'h0;
        prevChan_q  <= `CH_INVALID;
        trigFired_q <= 1'b0;
      end else if (sensing) begin
        prevChan_q <= channelState;
        if (trigger)
          trigFired_q <= 1'b1;
        if (correlationSourceEnable) begin
          corrState_q <= corrState_d;
          peakRun_q   <= peakRun_d;
          if (corrPeak) begin
            lastPeak_q <= radioTimer;
            havePeak_q <= 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/cs_monitor.sv ***
// checker for the carrier-sense engine, port-level relations only
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "cs_regs.vh"
module cs_monitor (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // command and configuration
  input wire logic       cmdStart,
  input wire logic [1:0] cmdKind,
  input wire logic       stopReq,
  input wire logic       abortReq,
  input wire logic       radioSetupOk,
  input wire logic       strengthSourceEnable,
  input wire logic       correlationSourceEnable,
  input wire logic [3:0] correlationIdleCount,
  input wire logic       combineSelect,
  input wire logic       synthOffOnBusy,
  input wire logic       synthOffOnIdle,
  // status
  input wire logic       cmdBusy,
  input wire logic       senseActive,
  input wire logic       correlatorPreamble,
  input wire logic [1:0] strengthState,
  input wire logic [1:0] correlationState,
  input wire logic [1:0] channelState,
  input wire logic       opDone,
  input wire logic [3:0] doneStatus,
  input wire logic [1:0] doneResult,
  input wire logic       synthOff
);
  logic take;
  logic cfgOk;
  logic busyEnd;
  logic idleEnd;
  assign take = cmdStart && !cmdBusy;
  // correlation needs a nonzero idle count, else the start is refused
  assign cfgOk = (strengthSourceEnable || correlationSourceEnable) &&
                 !(correlationSourceEnable && correlationIdleCount == 4'h0);
  assign busyEnd = doneStatus == `ST_DONE_BUSY || doneStatus == `ST_BUSY_TIMEOUT;
  assign idleEnd = doneStatus == `ST_DONE_IDLE || doneStatus == `ST_IDLE_TIMEOUT;
  function automatic [1:0] mix(input s, input c, input sel, input [1:0] a, input [1:0] b);
    if (!c) mix = a;
    else if (!s) mix = b;
    else if (!sel) mix = (a == `CH_BUSY || b == `CH_BUSY) ? `CH_BUSY :
                         (a == `CH_IDLE && b == `CH_IDLE) ? `CH_IDLE : `CH_INVALID;
    else mix = (a == `CH_IDLE || b == `CH_IDLE) ? `CH_IDLE :
               (a == `CH_BUSY && b == `CH_BUSY) ? `CH_BUSY : `CH_INVALID;
  endfunction
  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_end(logic [3:0] st, logic [1:0] res);
    opDone && doneStatus == st && doneResult == res;
  endsequence
  property p_states;
    strengthState != 2'h3 && correlationState != 2'h3;
  endproperty
  a_states: assert property (p_states) else $error("source state out of range");
  property p_mix;
    senseActive |-> channelState == mix(strengthSourceEnable, correlationSourceEnable,
                                        combineSelect, strengthState, correlationState);
  endproperty
  a_mix: assert property (p_mix) else $error("channel state wrong");
  property p_par;
    take && !cfgOk |=> s_end(`ST_ERR_PAR, `RES_ABORT);
  endproperty
  a_par: assert property (p_par) else $error("bad parameter not refused");
  property p_setup;
    take && cfgOk && cmdKind == `CMD_STANDALONE && !radioSetupOk
      |=> s_end(`ST_ERR_SETUP, `RES_ABORT);
  endproperty
  a_setup: assert property (p_setup) else $error("missing setup not refused");
  property p_abort;
    cmdBusy && abortReq |=> s_end(`ST_ABORT, `RES_ABORT);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
  property p_stop;
    cmdBusy && stopReq && !abortReq |=> s_end(`ST_STOPPED, `RES_FALSE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_res;
    opDone && (busyEnd || idleEnd) |-> doneResult == (busyEnd ? `RES_TRUE : `RES_FALSE);
  endproperty
  a_res: assert property (p_res) else $error("result wrong for status");
  property p_hold;
    !opDone |-> $stable(doneStatus) && $stable(doneResult);
  endproperty
  a_hold: assert property (p_hold) else $error("status moved between ends");
  property p_synth;
    synthOff |-> opDone && (busyEnd ? synthOffOnBusy : idleEnd ? synthOffOnIdle :
                            synthOffOnBusy || synthOffOnIdle);
  endproperty
  a_synth: assert property (p_synth) else $error("synth off wrongly");
  property p_pre;
    senseActive && correlationSourceEnable |-> correlatorPreamble;
  endproperty
  a_pre: assert property (p_pre) else $error("correlator not on preamble");
endmodule
bind carrier_sense_engine cs_monitor mon (.*);
`default_nettype wire

// *** tb/radio_model.sv ***
// radio side: free-running tick count, strength samples, correlation peaks
// assumes one tick per clock and a receiver settled one cycle after start
`timescale 1ns/1ps
`default_nettype none
module radio_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // control
  input  wire logic        running,
  input  wire logic [7:0]  level,
  input  wire logic [7:0]  peakGap,
  // modem side
  output var  logic [31:0] radioTimer,
  output var  logic        receiverReady,
  output var  logic        strengthValid,
  output var  logic [7:0]  strengthSample,
  output var  logic        corrPeak
);
  logic [7:0] gap_q;
  // ==========================================================
  // sample line toggles to its inverse every cycle between samples, so stale data is caught
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      radioTimer <= 32'h0;
      receiverReady <= 1'b0;
      strengthValid <= 1'b0;
      strengthSample <= 8'h00;
      corrPeak <= 1'b0;
      gap_q <= 8'h00;
    end else begin
      radioTimer <= radioTimer + 32'h1;
      receiverReady <= running;
      strengthValid <= receiverReady && radioTimer[1:0] == 2'h3;
      strengthSample <= (receiverReady && radioTimer[1:0] == 2'h3) ? level : ~strengthSample;
      // a gap shortened mid-run restarts at once instead of waiting for a wrap
      gap_q <= (gap_q >= peakGap - 8'h1) ? 8'h00 : gap_q + 8'h1;
      corrPeak <= receiverReady && peakGap != 8'h00 && gap_q == peakGap - 8'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// bench for the carrier-sense engine: command sequences with expected ends
// assumes the radio model supplies timer, samples and peaks
`timescale 1ns/1ps
`default_nettype none
`include "cs_regs.vh"
module tb;
  logic clock = 0;
  logic rst = 1;
  logic cmdStart, stopReq, abortReq, radioSetupOk, synthProgrammed;
  logic strengthSourceEnable, correlationSourceEnable, combineSelect;
  logic busyAction, idleAction, timeoutSelector, synthOffOnBusy, synthOffOnIdle;
  logic syncFound, syncSearchRestart, receiverReady, strengthValid, corrPeak;
  logic cmdBusy, senseActive, correlatorPreamble, opDone, synthOff;
  logic [1:0] cmdKind, endTriggerKind, strengthState, correlationState;
  logic [1:0] channelState, doneResult;
  logic [3:0] correlationInvalidCount, correlationBusyCount, correlationIdleCount;
  logic [3:0] doneStatus;
  logic [7:0] strengthThreshold, strengthIdleCount, strengthBusyCount, level, peakGap;
  logic [7:0] strengthSample;
  logic [31:0] correlationPeriod, correlationTimeout, endTriggerTime, radioTimer;
  int errors = 0;
  int cmpCount = 0;
  int i;
  carrier_sense_engine dut (.*);
  radio_model radio (.clock(clock), .rst(rst), .running(cmdBusy), .level(level),
    .peakGap(peakGap), .radioTimer(radioTimer), .receiverReady(receiverReady),
    .strengthValid(strengthValid), .strengthSample(strengthSample), .corrPeak(corrPeak));
  always #2 clock = ~clock;
  // ==========================================================
  // tasks
  task tick;
    @(posedge clock);
    #1;
  endtask
  task stopTest;
    $display("checks %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task start(input logic [1:0] k);
    cmdKind = k;
    cmdStart = 1;
    tick;
    cmdStart = 0;
  endtask
  // opDone stands one cycle, so it is sampled after every edge
  task waitEnd(input logic [3:0] st, input logic [1:0] res, input logic syn, input logic ck);
    int n;
    n = 0;
    while (opDone !== 1'b1 && n < 400) begin
      tick;
      n++;
    end
    cmpCount++;
    if (n == 400) begin
      errors++;
      $display("unexpected at %0t: no end seen", $time);
      stopTest;
    end else begin
      if (doneStatus !== st || doneResult !== res || (ck && synthOff !== syn)) begin
        errors++;
        $display("unexpected at %0t: end %h/%h", $time, doneStatus, doneResult);
      end
      tick;
    end
  endtask
  // level check on status outputs; an unknown counts as a miss
  task check(input logic ok);
    cmpCount++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: status level wrong", $time);
    end
  endtask
  // ==========================================================
  // sequence
  initial begin
    {cmdStart, stopReq, abortReq, syncFound, syncSearchRestart, combineSelect} = 6'h00;
    {radioSetupOk, synthProgrammed, strengthSourceEnable} = 3'h7;
    {correlationSourceEnable, timeoutSelector, idleAction} = 3'h0;
    {busyAction, synthOffOnBusy, synthOffOnIdle} = 3'h6;
    cmdKind = `CMD_STANDALONE;
    endTriggerKind = `TRIG_NEVER;
    endTriggerTime = 32'h28;
    strengthThreshold = 8'h10;
    strengthIdleCount = 8'h03;
    strengthBusyCount = 8'h03;
    correlationPeriod = 32'h28;
    correlationTimeout = 32'h14;
    correlationInvalidCount = 4'h2;
    correlationBusyCount = 4'h2;
    correlationIdleCount = 4'h1;
    level = 8'h10;
    peakGap = 8'h00;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    strengthSourceEnable = 0;
    start(`CMD_STANDALONE);
    waitEnd(`ST_ERR_PAR, `RES_ABORT, 1, 1);
    strengthSourceEnable = 1;
    radioSetupOk = 0;
    start(`CMD_STANDALONE);
    waitEnd(`ST_ERR_SETUP, `RES_ABORT, 1, 1);
    radioSetupOk = 1;
    synthProgrammed = 0;
    start(`CMD_STANDALONE);
    waitEnd(`ST_ERR_SYNTH, `RES_ABORT, 1, 1);
    synthProgrammed = 1;
    $display("test errors done");
    endTriggerKind = `TRIG_REL;
    for (i = 0; i < 2; i++) begin
      timeoutSelector = i[0];
      start(`CMD_STANDALONE);
      waitEnd(i ? `ST_IDLE_TIMEOUT : `ST_BUSY_TIMEOUT, i ? `RES_FALSE : `RES_TRUE,
              !i[0], 1);
    end
    $display("test timeout done");
    endTriggerKind = `TRIG_NEVER;
    start(`CMD_STANDALONE);
    repeat (6) tick;
    stopReq = 1;
    tick;
    stopReq = 0;
    waitEnd(`ST_STOPPED, `RES_FALSE, 1, 1);
    start(`CMD_SNIFF_BASIC);
    repeat (6) tick;
    abortReq = 1;
    tick;
    abortReq = 0;
    waitEnd(`ST_ABORT, `RES_ABORT, 0, 1);
    $display("test stop abort done");
    // strength busy early; corr goes idle only when its period runs out
    {correlationSourceEnable, busyAction, idleAction, level} = {3'h7, 8'h30};
    for (i = 0; i < 2; i++) begin
      combineSelect = i[0];
      start(`CMD_STANDALONE);
      waitEnd(i ? `ST_DONE_IDLE : `ST_DONE_BUSY, i ? `RES_FALSE : `RES_TRUE,
              !i[0], 1);
    end
    $display("test combine done");
    {strengthSourceEnable, peakGap} = {1'b0, 8'h03};
    start(`CMD_STANDALONE);
    waitEnd(`ST_DONE_BUSY, `RES_TRUE, 1, 1);
    {peakGap, busyAction, idleAction, endTriggerKind} = {8'h00, 2'h0, `TRIG_REL};
    endTriggerTime = 32'h3C;
    for (i = 1; i < 3; i++) begin
      start(i[1:0]);
      waitEnd(`ST_DONE_IDLE, `RES_FALSE, 0, 1);
    end
    $display("test sniff done");
    // sniff with no end: correlation walks idle, busy, idle around a sync hold
    endTriggerKind = `TRIG_NEVER;
    start(`CMD_SNIFF_BASIC);
    repeat (50) tick;
    check(correlationState === `CH_IDLE);
    syncFound = 1;
    tick;
    syncFound = 0;
    check(cmdBusy === 1'b1 && senseActive === 1'b0);
    syncSearchRestart = 1;
    tick;
    syncSearchRestart = 0;
    check(senseActive === 1'b1);
    peakGap = 8'h03;
    repeat (20) tick;
    check(correlationState === `CH_BUSY);
    peakGap = 8'h00;
    repeat (30) tick;
    check(correlationState === `CH_IDLE);
    stopReq = 1;
    tick;
    stopReq = 0;
    waitEnd(`ST_STOPPED, `RES_FALSE, 0, 1);
    $display("test hold done");
    // negative level must count as below a positive threshold
    {strengthSourceEnable, correlationSourceEnable, busyAction, idleAction} = 4'hB;
    level = 8'hF0;
    start(`CMD_STANDALONE);
    waitEnd(`ST_DONE_IDLE, `RES_FALSE, 0, 1);
    {level, endTriggerKind} = {8'h10, `TRIG_ABS};
    endTriggerTime = radioTimer + 32'h20;
    start(`CMD_STANDALONE);
    waitEnd(`ST_IDLE_TIMEOUT, `RES_FALSE, 0, 1);
    $display("test strength done");
    stopTest;
  end
endmodule
`default_nettype wire
